// File: dv/phase_feedback_receiver_sva.sv
`timescale 1ns/1ps
module phase_feedback_receiver_sva (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic [2:0]         regulation_stage_i,
   input wire logic [2:0]         transient_stage_i,
   input wire logic [2:0]         ovuv_stage_i,
   input wire logic [5:0]         voltage_code_i,
   input wire logic [7:0]         trip_levels_i,
   input wire logic [7:0]         ovuv_levels_i,
   input wire logic               transient_high_trip_i,
   input wire logic               transient_low_trip_i,
   input wire logic               cfg_ready_i,
   input wire logic               cfg_valid_o,
   input wire logic [2:0]         cfg_stage_o,
   input wire pfr_pkg::cfg_step_t cfg_kind_o,
   input wire logic [7:0]         cfg_data_o,
   input wire logic               soft_start_o,
   input wire logic [5:0]         pwm_o,
   input wire logic [5:0]         low_side_drive_o,
   input wire logic               fast_transient_mode_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // one accepted step of the stage setup walk
   sequence take_s(pfr_pkg::cfg_step_t k);
      cfg_valid_o && cfg_ready_i && cfg_kind_o == k;
   endsequence

   // setup steps follow each other in a fixed order
   vcode_next_a: assert property (
      take_s(pfr_pkg::CFG_VCODE) |=> cfg_kind_o == pfr_pkg::CFG_TRIP)
      else $error("step after voltage code is wrong");
   trip_next_a: assert property (
      take_s(pfr_pkg::CFG_TRIP) |=> cfg_kind_o == pfr_pkg::CFG_OVUV)
      else $error("step after trip levels is wrong");
   run_entry_a: assert property (
      take_s(pfr_pkg::CFG_OVUV) |=> !cfg_valid_o && soft_start_o)
      else $error("setup did not finish into run");
   request_hold_a: assert property (
      cfg_valid_o && !cfg_ready_i |=> cfg_valid_o && $stable(cfg_kind_o))
      else $error("setup request dropped before taken");

   // each step goes to its stage with its payload
   vcode_payload_a: assert property (
      cfg_valid_o && cfg_kind_o == pfr_pkg::CFG_VCODE |->
      cfg_stage_o == regulation_stage_i &&
      cfg_data_o == {2'b00, voltage_code_i})
      else $error("voltage code request malformed");
   trip_payload_a: assert property (
      cfg_valid_o && cfg_kind_o == pfr_pkg::CFG_TRIP |->
      cfg_stage_o == transient_stage_i && cfg_data_o == trip_levels_i)
      else $error("trip level request malformed");
   ovuv_payload_a: assert property (
      cfg_valid_o && cfg_kind_o == pfr_pkg::CFG_OVUV |->
      cfg_stage_o == ovuv_stage_i && cfg_data_o == ovuv_levels_i)
      else $error("over/under request malformed");

   // drive outputs stay off until soft start, then never overlap
   pwm_gate_a: assert property (
      !soft_start_o |-> pwm_o == 6'h00 && low_side_drive_o == 6'h00)
      else $error("phase drive active before soft start");
   lsd_follow_a: assert property (
      soft_start_o && $past(soft_start_o) |-> low_side_drive_o == ~pwm_o)
      else $error("low side drive not complement of pwm");

   // transient trips act on all phases at the next edge
   high_trip_a: assert property (
      soft_start_o && transient_high_trip_i |=>
      fast_transient_mode_o && pwm_o == 6'h3F)
      else $error("high trip did not align phases");
   low_trip_a: assert property (
      soft_start_o && transient_low_trip_i && !transient_high_trip_i |=>
      fast_transient_mode_o && pwm_o == 6'h00)
      else $error("low trip did not remove phases");
   trip_exit_a: assert property (
      !transient_high_trip_i && !transient_low_trip_i |=>
      !fast_transient_mode_o)
      else $error("transient mode outlived its trip");
endmodule

// File: dv/phase_feedback_receiver_tb_top.sv
`timescale 1ns/1ps
module phase_feedback_receiver_tb_top;
   logic                clk, rst, high_trip, low_trip, cfg_ready, slow;
   logic                cfg_valid, soft_start, fast, sclk;
   logic [7:0]          gain, kp, ki, cfg_data, offset;
   logic [5:0]          cur_line, err_line, soc, pwm, lsd;
   logic [2:0]          cfg_stage;
   pfr_pkg::cfg_step_t  cfg_kind;
   logic [2:0]          act     = 3'h6;
   logic [2:0]          reg_st  = 3'h2;
   logic [2:0]          tr_st   = 3'h0;
   logic [2:0]          ov_st   = 3'h1;
   logic [5:0]          vcode   = 6'h2A;
   logic [7:0]          trip_lv = 8'h5C;
   logic [7:0]          ovuv_lv = 8'hA3;
   int                  n_mismatch = 0;
   int                  compares = 0;

   phase_feedback_receiver u_dut (
      .clk_i(clk), .rst_i(rst), .phase_current_serial_i(cur_line),
      .voltage_error_i(err_line), .conv_start_i(soc),
      .transient_high_trip_i(high_trip), .transient_low_trip_i(low_trip),
      .active_phases_i(act), .regulation_stage_i(reg_st),
      .transient_stage_i(tr_st), .ovuv_stage_i(ov_st),
      .voltage_code_i(vcode), .trip_levels_i(trip_lv),
      .ovuv_levels_i(ovuv_lv), .load_line_gain_i(gain), .kp_i(kp),
      .ki_i(ki), .cfg_ready_i(cfg_ready), .shared_stage_clock_o(sclk),
      .cfg_valid_o(cfg_valid), .cfg_stage_o(cfg_stage),
      .cfg_kind_o(cfg_kind), .cfg_data_o(cfg_data),
      .soft_start_o(soft_start), .pwm_o(pwm), .low_side_drive_o(lsd),
      .target_offset_o(offset), .fast_transient_mode_o(fast));

   power_stage_model u_stage (
      .clk_i(sclk), .pwm_i(pwm), .slow_i(slow), .cur_line_o(cur_line),
      .err_line_o(err_line), .soc_o(soc));

   // clock: starts low, toggles every 25 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic t_reset;
      #1 check("cfg valid", {7'h00, cfg_valid}, 8'h01);
      check("pwm in reset", {2'b00, pwm}, 8'h00);
      check("offset in reset", offset, 8'h00);
      check("soft start", {7'h00, soft_start}, 8'h00);
      @(negedge clk) #1 check("stage clock low", {7'h00, sclk}, 8'h00);
      #30 check("stage clock high", {7'h00, sclk}, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_config;
      repeat (3) @(posedge clk);
      #1 check("held kind", 8'(cfg_kind), 8'(pfr_pkg::CFG_VCODE));
      check("vcode data", cfg_data, {2'b00, vcode});
      check("vcode stage", {5'h00, cfg_stage}, {5'h00, reg_st});
      @(posedge clk) cfg_ready <= 1'b1;
      @(posedge clk);
      #1 check("trip kind", 8'(cfg_kind), 8'(pfr_pkg::CFG_TRIP));
      check("trip data", cfg_data, trip_lv);
      check("trip stage", {5'h00, cfg_stage}, {5'h00, tr_st});
      @(posedge clk);
      #1 check("ovuv kind", 8'(cfg_kind), 8'(pfr_pkg::CFG_OVUV));
      check("ovuv data", cfg_data, ovuv_lv);
      check("ovuv stage", {5'h00, cfg_stage}, {5'h00, ov_st});
      @(posedge clk);
      #1 check("setup done", {6'h00, cfg_valid, soft_start}, 8'h01);
      @(posedge clk) cfg_ready <= 1'b0;
      $display("test config done");
   endtask

   task automatic measure(output logic [7:0] d [6]);
      foreach (d[k]) d[k] = 8'h00;
      repeat (pfr_pkg::PWM_PERIOD) begin
         @(posedge clk);
         #1 foreach (d[k]) d[k] += 8'(pwm[k]);
      end
   endtask

   task automatic t_balance;
      logic [7:0] d [6];
      repeat (400) @(posedge clk);
      measure(d);
      for (int k = 1; k < 6; k++) check("equal duty", d[k], d[0]);
      @(posedge clk) slow <= 1'b1;
      u_stage.cur_val[0] = 6'h20; // bit order reversal would invert this
      repeat (400) @(posedge clk);
      measure(d);
      check("heavy phase trimmed", 8'(d[0] < d[1]), 8'h01);
      // too few phases requested: clamp keeps three, the rest stay off
      @(posedge clk) act <= 3'h2;
      measure(d);
      check("dropped phase idle", d[3], 8'h00);
      check("third phase kept", 8'(d[2] != 8'h00), 8'h01);
      @(posedge clk) act <= 3'h6;
      $display("test balance done");
   endtask

   task automatic wait_offset(input logic [7:0] exp);
      for (int i = 0; i < 60 && offset !== exp; i++) begin
         @(posedge clk);
         #1;
      end
      check("target offset", offset, exp);
   endtask

   task automatic t_error;
      @(posedge clk) kp <= 8'h10;
      u_stage.send_err(3'h4, 6'h1F);
      repeat (40) @(posedge clk);
      #1 check("other stage ignored", offset, 8'h00);
      u_stage.send_err(reg_st, 6'h1F);
      wait_offset(8'h1F);
      u_stage.send_err(reg_st, 6'h20);
      wait_offset(8'hE0);
      $display("test error done");
   endtask

   task automatic t_load_line;
      @(posedge clk) gain <= 8'hFF;
      repeat (600) @(posedge clk);
      u_stage.send_err(reg_st, 6'h00);
      repeat (40) @(posedge clk);
      #1 check("load line lowers", {7'h00, offset[7]}, 8'h01);
      $display("test load line done");
   endtask

   task automatic t_trip;
      @(posedge clk) high_trip <= 1'b1;
      @(posedge clk);
      #1 check("high trip mode", {7'h00, fast}, 8'h01);
      check("phases aligned", {2'b00, pwm}, 8'h3F);
      @(posedge clk) begin
         high_trip <= 1'b0;
         low_trip  <= 1'b1;
      end
      @(posedge clk);
      #1 check("phases removed", {2'b00, pwm}, 8'h00);
      @(posedge clk) low_trip <= 1'b0;
      @(posedge clk);
      #1 check("trip mode left", {7'h00, fast}, 8'h00);
      $display("test trip done");
   endtask

   // main sequence
   initial begin
      {rst, high_trip, low_trip, cfg_ready, slow} = 5'b10000;
      {gain, kp, ki} = 24'h000000;
      repeat (8) @(posedge clk);
      t_reset();
      @(posedge clk) rst <= 1'b0;
      t_config();
      t_balance();
      t_error();
      t_load_line();
      t_trip();
      print_verdict();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      print_verdict();
   end
endmodule

bind phase_feedback_receiver phase_feedback_receiver_sva u_sva (
   .clk_i, .rst_i, .regulation_stage_i, .transient_stage_i, .ovuv_stage_i,
   .voltage_code_i, .trip_levels_i, .ovuv_levels_i, .transient_high_trip_i,
   .transient_low_trip_i, .cfg_ready_i, .cfg_valid_o, .cfg_stage_o,
   .cfg_kind_o, .cfg_data_o, .soft_start_o, .pwm_o, .low_side_drive_o,
   .fast_transient_mode_o);

// File: dv/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model #(
   parameter int CONV_CYC = 7
) (
   input  wire logic       clk_i,
   input  wire logic [5:0] pwm_i,
   input  wire logic       slow_i,
   output logic [5:0]      cur_line_o,
   output logic [5:0]      err_line_o,
   output logic [5:0]      soc_o
);
   logic [5:0] cur_val [6];

   // lines idle low, every stage starts with the same current
   initial begin
      cur_line_o = 6'h00;
      err_line_o = 6'h00;
      soc_o      = 6'h00;
      foreach (cur_val[k]) cur_val[k] = 6'h06;
   end

   // every stage answers each pwm fall with a current frame
   for (genvar k = 0; k < 6; k++) begin : g_ph
      always begin
         @(negedge pwm_i[k]);
         repeat (CONV_CYC + int'(slow_i)) @(posedge clk_i);
         cur_line_o[k] <= 1'b1;
         repeat (2) @(posedge clk_i);
         for (int b = 5; b >= 0; b--) begin
            cur_line_o[k] <= cur_val[k][b];
            repeat (2) @(posedge clk_i);
         end
         cur_line_o[k] <= 1'b0;
      end
   end

   // voltage frame: strobe two cycles, gap two, six bits msb first
   task automatic send_err(input logic [2:0] st, input logic [5:0] v);
      @(posedge clk_i);
      soc_o[st] <= 1'b1;
      repeat (2) @(posedge clk_i);
      soc_o[st] <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int b = 5; b >= 0; b--) begin
         err_line_o[st] <= v[b];
         repeat (2) @(posedge clk_i);
      end
      err_line_o[st] <= ~v[0]; // released line shows no stale bit
   endtask
endmodule

// File: rtl/pfr_pkg.sv
// What this block does
// - current frame is one start bit then six data bits, MSB first
// - each serial bit lasts two shared clock cycles
// - every current line is watched for a start bit whenever its receiver is idle
// - average the active phase currents and trim each phase drive toward it
// - two cycles after strobe, six error bits arrive MSB first
// - voltage error is taken from the one designated regulation stage only
// - voltage code goes to regulation stage over config bus before soft start
// - each strobe-started voltage frame counts as exactly one sample
// - at least three stages hold regulation, transient and over/under roles
// - one stage gets transient trip levels, another over/under voltage setup
// - load-line path scales average current by a gain and low-pass filters
// - filtered load-line value is subtracted from the voltage error sample
// - compensated result drives all phases as a common target offset
// - shared stage clock is supplied and times all serial reception
// - transient trip immediately aligns or removes all phases
package pfr_pkg;
   localparam int NPH        = 6;
   localparam int SMP_W      = 6;
   localparam int IDX_W      = 3;
   localparam int FIFO_DEPTH = 8;
   localparam int BIT_CYC    = 2;
   localparam int CUR_FIRST  = 3;
   localparam int VOLT_FIRST = 5;
   localparam int MIN_PH     = 3;
   localparam int PWM_PERIOD = 40;
   localparam int BASE_DUTY  = 20;
   localparam int PH_STEP    = 7;
   localparam int LPF_SHIFT  = 3;
   localparam int LL_SHIFT   = 4;
   localparam int COMP_SHIFT = 4;
   localparam int AVG_SHIFT  = 8;
   typedef enum logic [1:0] {
      CFG_VCODE, CFG_TRIP, CFG_OVUV, CFG_RUN
   } cfg_step_t;
endpackage

// File: rtl/phase_feedback_receiver.sv
`timescale 1ns/1ps
module phase_feedback_receiver (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [5:0]            phase_current_serial_i,
   input  wire logic [5:0]            voltage_error_i,
   input  wire logic [5:0]            conv_start_i,
   input  wire logic                  transient_high_trip_i,
   input  wire logic                  transient_low_trip_i,
   input  wire logic [2:0]            active_phases_i,
   input  wire logic [2:0]            regulation_stage_i,
   input  wire logic [2:0]            transient_stage_i,
   input  wire logic [2:0]            ovuv_stage_i,
   input  wire logic [5:0]            voltage_code_i,
   input  wire logic [7:0]            trip_levels_i,
   input  wire logic [7:0]            ovuv_levels_i,
   input  wire logic [7:0]            load_line_gain_i,
   input  wire logic [7:0]            kp_i,
   input  wire logic [7:0]            ki_i,
   input  wire logic                  cfg_ready_i,
   output logic                       shared_stage_clock_o,
   output logic                       cfg_valid_o,
   output logic [2:0]                 cfg_stage_o,
   output pfr_pkg::cfg_step_t         cfg_kind_o,
   output logic [7:0]                 cfg_data_o,
   output logic                       soft_start_o,
   output logic [5:0]                 pwm_o,
   output logic [5:0]                 low_side_drive_o,
   output logic [7:0]                 target_offset_o,
   output logic                       fast_transient_mode_o
);
   localparam int NPH = pfr_pkg::NPH;
   localparam int SW  = pfr_pkg::SMP_W;
   localparam int FW  = pfr_pkg::IDX_W + pfr_pkg::SMP_W;

   pfr_pkg::cfg_step_t cfg_r;
   logic [5:0]         pwm_d_r;
   logic [SW-1:0]      rx_data  [NPH];
   logic [NPH-1:0]     rx_valid;
   logic [NPH-1:0]     pend_r;
   logic [SW-1:0]      pend_dat_r [NPH];
   logic [SW-1:0]      cur_r    [NPH];
   logic               fin_valid;
   logic               fin_ready;
   logic [FW-1:0]      fin_data;
   logic               fout_valid;
   logic               fout_ready;
   logic [FW-1:0]      fout_data;
   logic [2:0]         pick;
   logic [2:0]         nact;
   logic [8:0]         sum;
   logic [SW-1:0]      avg;
   logic [SW-1:0]      verr;
   logic               verr_valid;
   logic [11:0]        ll_raw;
   logic signed [12:0] filt_r;
   logic signed [12:0] err_r;
   logic               upd_r;
   logic signed [23:0] integ_r;
   logic signed [23:0] comp;
   logic [5:0]         cnt_r;
   logic               run;
   logic [5:0]         pwm_nxt;

   // lowest pending phase wins the fifo slot
   function automatic logic [2:0] first_set(input logic [5:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int k = NPH - 1; k >= 0; k--) begin
         if (v[k]) r = 3'(k);
      end
      return r;
   endfunction

   // 2^8 / n for the phase average
   function automatic logic [7:0] recip(input logic [2:0] n);
      logic [7:0] r;
      unique case (n)
         3'h4:    r = 8'h40;
         3'h5:    r = 8'h33;
         3'h6:    r = 8'h2B;
         default: r = 8'h56;
      endcase
      return r;
   endfunction

   // clk_i is the shared stage clock forwarded to every stage
   assign shared_stage_clock_o = clk_i;
   assign run = (cfg_r == pfr_pkg::CFG_RUN);
   assign soft_start_o = run;

   // stage setup sequence before soft start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_r <= pfr_pkg::CFG_VCODE;
      end else if (cfg_valid_o && cfg_ready_i) begin
         unique case (cfg_r)
            pfr_pkg::CFG_VCODE: cfg_r <= pfr_pkg::CFG_TRIP;
            pfr_pkg::CFG_TRIP:  cfg_r <= pfr_pkg::CFG_OVUV;
            pfr_pkg::CFG_OVUV:  cfg_r <= pfr_pkg::CFG_RUN;
            pfr_pkg::CFG_RUN:   cfg_r <= pfr_pkg::CFG_RUN;
         endcase
      end
   end

   // config bus request for the current step
   always_comb begin
      cfg_valid_o = ~run;
      cfg_kind_o  = cfg_r;
      cfg_stage_o = regulation_stage_i;
      cfg_data_o  = {2'h0, voltage_code_i};
      unique case (cfg_r)
         pfr_pkg::CFG_TRIP: begin
            cfg_stage_o = transient_stage_i;
            cfg_data_o  = trip_levels_i;
         end
         pfr_pkg::CFG_OVUV: begin
            cfg_stage_o = ovuv_stage_i;
            cfg_data_o  = ovuv_levels_i;
         end
         default: begin
         end
      endcase
   end

   // one current receiver per phase, a falling pwm abandons any frame in progress
   for (genvar i = 0; i < NPH; i++) begin : g_rx
      serial_sample_rx #(.START_BIT(1'b1)) u_cur (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .line_i  (phase_current_serial_i[i]),
         .strobe_i(1'b0),
         .abort_i (pwm_d_r[i] & ~pwm_o[i]),
         .data_o  (rx_data[i]),
         .valid_o (rx_valid[i])
      );
   end

   // pending slot per phase, a new frame beats the fifo take
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r <= '0;
         for (int k = 0; k < NPH; k++) pend_dat_r[k] <= '0;
      end else begin
         for (int k = 0; k < NPH; k++) begin
            if (rx_valid[k]) begin
               pend_r[k]     <= 1'b1;
               pend_dat_r[k] <= rx_data[k];
            end else if (fin_ready && pick == 3'(k) && pend_r[k]) begin
               pend_r[k] <= 1'b0;
            end
         end
      end
   end

   assign pick      = first_set(pend_r);
   assign fin_valid = |pend_r;
   assign fin_data  = {pick, pend_dat_r[pick]};
   // drain stalls while the voltage path updates
   assign fout_ready = ~upd_r;

   sample_fifo #(.W(FW), .DEPTH(pfr_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .in_valid_i (fin_valid),
      .in_ready_o (fin_ready),
      .in_data_i  (fin_data),
      .out_valid_o(fout_valid),
      .out_ready_i(fout_ready),
      .out_data_o (fout_data)
   );

   // latest current per phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int k = 0; k < NPH; k++) cur_r[k] <= '0;
      end else if (fout_valid && fout_ready) begin
         cur_r[fout_data[FW-1:SW]] <= fout_data[SW-1:0];
      end
   end

   // active phase count clamped to three..six
   always_comb begin
      nact = active_phases_i;
      if (active_phases_i < 3'(pfr_pkg::MIN_PH)) nact = 3'(pfr_pkg::MIN_PH);
      if (active_phases_i > 3'(NPH)) nact = 3'(NPH);
   end

   // average of active phases
   always_comb begin
      logic [16:0] prod;
      prod = 17'h00000;
      sum = 9'h000;
      for (int k = 0; k < NPH; k++) begin
         if (3'(k) < nact) sum = sum + 9'(cur_r[k]);
      end
      prod = 17'(sum) * 17'(recip(nact));
      avg  = SW'(prod >> pfr_pkg::AVG_SHIFT);
   end

   // voltage error from the designated stage only
   serial_sample_rx #(.START_BIT(1'b0)) u_verr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .line_i  (voltage_error_i[regulation_stage_i]),
      .strobe_i(conv_start_i[regulation_stage_i]),
      .abort_i (1'b0),
      .data_o  (verr),
      .valid_o (verr_valid)
   );

   // load-line value: gain times average, then first-order filter
   assign ll_raw = 12'((14'(avg) * 14'(load_line_gain_i))
                       >> pfr_pkg::LL_SHIFT);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_r <= 13'sh0000;
      end else begin
         filt_r <= filt_r + ((13'($signed({1'b0, ll_raw})) - filt_r)
                             >>> pfr_pkg::LPF_SHIFT);
      end
   end

   // error less load-line on each strobe sample, then PI compensation
   assign comp = (24'(err_r) * 24'($signed({1'b0, kp_i})) + integ_r)
                 >>> pfr_pkg::COMP_SHIFT;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_r           <= 13'sh0000;
         upd_r           <= 1'b0;
         integ_r         <= 24'sh000000;
         target_offset_o <= 8'h00;
      end else begin
         upd_r <= verr_valid;
         if (verr_valid) begin
            err_r <= 13'($signed(verr)) - filt_r;
         end
         if (upd_r) begin
            integ_r <= integ_r + 24'(err_r) * 24'($signed({1'b0, ki_i}));
            if (comp > 24'sd127) target_offset_o <= 8'h7F;
            else if (comp < -24'sd128) target_offset_o <= 8'h80;
            else target_offset_o <= comp[7:0];
         end
      end
   end

   // shared pwm period counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 6'h00;
      end else if (cnt_r == 6'(pfr_pkg::PWM_PERIOD - 1)) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // per-phase duty: common offset minus balance trim, staggered phases
   always_comb begin
      logic signed [9:0] duty;
      logic [6:0]        pc;
      duty    = 10'sd0;
      pc      = 7'h00;
      pwm_nxt = 6'h00;
      for (int k = 0; k < NPH; k++) begin
         duty = 10'(pfr_pkg::BASE_DUTY)
              + 10'($signed(target_offset_o))
              - (10'($signed({1'b0, cur_r[k]}))
                 - 10'($signed({1'b0, avg})));
         pc = 7'(cnt_r) + 7'(k * pfr_pkg::PH_STEP);
         if (pc >= 7'(pfr_pkg::PWM_PERIOD)) begin
            pc = pc - 7'(pfr_pkg::PWM_PERIOD);
         end
         pwm_nxt[k] = (3'(k) < nact) && (duty > $signed({3'b000, pc}));
      end
      if (transient_high_trip_i) pwm_nxt = 6'h3F;
      else if (transient_low_trip_i) pwm_nxt = 6'h00;
      if (!run) pwm_nxt = 6'h00;
   end

   // registered drive pins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwm_o                 <= 6'h00;
         pwm_d_r               <= 6'h00;
         low_side_drive_o      <= 6'h00;
         fast_transient_mode_o <= 1'b0;
      end else begin
         pwm_o   <= pwm_nxt;
         pwm_d_r <= pwm_o;
         low_side_drive_o <= run ? ~pwm_nxt : 6'h00;
         fast_transient_mode_o <= run & (transient_high_trip_i
                                         | transient_low_trip_i);
      end
   end
endmodule

// File: rtl/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         full;
   logic         empty;
   logic         do_wr;
   logic         do_rd;

   // full when pointers differ only in the wrap bit
   assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty = (wp_r == rp_r);
   assign in_ready_o  = ~full;
   assign out_valid_o = ~empty;
   assign do_wr = in_valid_i & ~full;
   assign do_rd = out_ready_i & ~empty;
   assign out_data_o = mem_r[rp_r[AW-1:0]];

   // storage
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_r[wp_r[AW-1:0]] <= in_data_i;
      end
   end

   // pointers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (do_wr) wp_r <= wp_r + 1'b1;
         if (do_rd) rp_r <= rp_r + 1'b1;
      end
   end
endmodule

// File: rtl/serial_sample_rx.sv
`timescale 1ns/1ps
module serial_sample_rx #(
   parameter bit START_BIT = 1'b1
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    line_i,
   input  wire logic                    strobe_i,
   input  wire logic                    abort_i,
   output logic [pfr_pkg::SMP_W-1:0]    data_o,
   output logic                         valid_o
);
   logic [1:0]                line_s_r;
   logic [1:0]                strb_s_r;
   logic                      strb_d_r;
   logic                      busy_r;
   logic [3:0]                wait_r;
   logic [2:0]                nbit_r;
   logic [pfr_pkg::SMP_W-1:0] sh_r;
   logic                      trig;

   // two-flop synchronisers, only the second flop is used downstream
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_s_r <= 2'h0;
         strb_s_r <= 2'h0;
         strb_d_r <= 1'b0;
      end else begin
         line_s_r <= {line_s_r[0], line_i};
         strb_s_r <= {strb_s_r[0], strobe_i};
         strb_d_r <= strb_s_r[1];
      end
   end

   // frame trigger: start bit on an idle line, or strobe rising edge
   assign trig = START_BIT ? line_s_r[1]
                           : (strb_s_r[1] & ~strb_d_r);

   // frame sequencer, samples the second cycle of each bit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_r  <= 1'b0;
         wait_r  <= 4'h0;
         nbit_r  <= 3'h0;
         sh_r    <= '0;
         data_o  <= '0;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         if (abort_i) begin
            busy_r <= 1'b0;
         end else if (!busy_r) begin
            if (trig) begin
               busy_r <= 1'b1;
               nbit_r <= 3'h0;
               wait_r <= START_BIT ? 4'(pfr_pkg::CUR_FIRST - 1)
                                   : 4'(pfr_pkg::VOLT_FIRST - 1);
            end
         end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
         end else begin
            sh_r   <= {sh_r[pfr_pkg::SMP_W-2:0], line_s_r[1]};
            wait_r <= 4'(pfr_pkg::BIT_CYC - 1);
            nbit_r <= nbit_r + 3'h1;
            if (nbit_r == 3'(pfr_pkg::SMP_W - 1)) begin
               busy_r  <= 1'b0;
               valid_o <= 1'b1;
               data_o  <= {sh_r[pfr_pkg::SMP_W-2:0], line_s_r[1]};
            end
         end
      end
   end
endmodule
